/* inc/mul_unit_cfg.svh */
`ifndef MUL_UNIT_CFG_SVH
`define MUL_UNIT_CFG_SVH
// What this block does
// - Single times double gives double pair
// - Single times single widened to double pair
// - NaN source gives NaN; signalling sets invalid
// - NaN result sign is XOR of signs
// - Infinity times infinity or normal gives infinity
// - Infinity times zero gives NaN, invalid
// - Zero source gives zero unless other special
// - Denormal source is zero, sets its flag
// - Denormal sets inexact unless other is zero or special
// - Rounded result sets inexact
// - Single by double: reads E1/E2, writes E6/E7
// - Two single to double: reads E1, writes E4/E5
// - Low result word written before high word
// - Signed by unsigned halfword, register or constant
// - Unsigned by signed halfword, written in E2
// - Single by single: reads E1, writes E4

// Halfword multiply operand forms
`define OPF_SU_REG 5'h1b
`define OPF_SU_CONST 5'h1e

// Floating-point encodings
`define SP_EXP_MAX 8'hff
`define DP_EXP_MAX 11'h7ff
`define SP_TO_DP_REBIAS 13'h0380
`define DP_BIAS 13'h03ff
`define NAN_SP_MAG 31'h7fff_ffff
`define NAN_DP_MAG 63'h7fff_ffff_ffff_ffff

// Write-back delay line length for the long operation
`define WB_PIPE_DEPTH 3

// Register map, byte addresses
`define REG_STATUS 4'h0
`define REG_CONTROL 4'h4
`define STATUS_BUSY_BIT 8
`define CONTROL_RESET 1'h1

`endif

/* inc/mul_unit_pkg.sv */
package mul_unit_pkg;

  // Operations issued by the decoder
  typedef enum logic [2:0] {
    op_idle,
    mul_single_by_double,
    mul_two_single_to_double,
    mul_single_single,
    mul16_signed_by_unsigned,
    mul16_unsigned_both,
    mul16_unsigned_by_signed
  } mul_op_type;

  // Exception flags of one floating-point result
  typedef struct packed {
    logic invalid_op_flag;
    logic inexact_flag;
    logic [1:0] denormal_input_flag;
  } fp_flags_type;

  // One issued operation in E1
  typedef struct packed {
    logic valid;
    logic pred;
    mul_op_type op;
    logic [4:0] opfield;
    logic [31:0] src1;
    logic [31:0] second_operand_low_word;
  } issue_type;

  // Operand decoded into classes, double layout
  typedef struct packed {
    logic sign;
    logic zero;
    logic den;
    logic inf;
    logic nan;
    logic snan;
    logic [10:0] exp;
    logic [51:0] frac;
  } op_class_type;

  // Floating-point result waiting for write-back
  typedef struct packed {
    logic valid;
    logic has_high;
    fp_flags_type flags;
    logic [31:0] low;
    logic [31:0] high;
  } wb_entry_type;

  // Special-value outcome of a product
  typedef enum logic [1:0] {
    kind_finite,
    kind_zero,
    kind_inf,
    kind_nan
  } res_kind_type;

endpackage

/* hw/fp_operand_class.sv */
`timescale 1ns/1ps
`default_nettype none
`include "mul_unit_cfg.svh"
module fp_operand_class (
  input wire logic [63:0] word, // Operand in double layout
  output mul_unit_pkg::op_class_type cls // Decoded classes
);

  // Split fields and classify; a denormal counts as zero
  always_comb
  begin
    cls.sign = word[63];
    cls.exp = word[62:52];
    cls.frac = word[51:0];
    cls.zero = (word[62:52] == 11'h000);
    cls.den = (word[62:52] == 11'h000) && (word[51:0] != 52'h0);
    cls.inf = (word[62:52] == `DP_EXP_MAX) && (word[51:0] == 52'h0);
    cls.nan = (word[62:52] == `DP_EXP_MAX) && (word[51:0] != 52'h0);
    cls.snan = cls.nan && !word[51];
  end

endmodule // fp_operand_class
`default_nettype wire

/* hw/int16_multiply.sv */
`timescale 1ns/1ps
`default_nettype none
`include "mul_unit_cfg.svh"
module int16_multiply (
  input wire mul_unit_pkg::mul_op_type op, // Selected operation
  input wire logic [4:0] opfield, // Register or constant form
  input wire logic [31:0] src1, // First operand
  input wire logic [31:0] src2, // Second operand
  output logic [31:0] product // Low 32 bits of product
);

  logic s1_signed;
  logic s2_signed;
  logic [15:0] a_half;
  logic [33:0] full;

  // Signedness comes only from the selected operation
  assign s1_signed = (op == mul_unit_pkg::mul16_signed_by_unsigned);
  assign s2_signed = (op == mul_unit_pkg::mul16_unsigned_by_signed);

  // Constant form sign-extends a 5-bit field
  assign a_half = (s1_signed && opfield == `OPF_SU_CONST) ? {{11{src1[4]}}, src1[4:0]}
                                                          : src1[15:0];

  // 17-bit signed multiply covers all three signedness mixes
  assign full = $signed({s1_signed & a_half[15], a_half})
              * $signed({s2_signed & src2[15], src2[15:0]});
  assign product = full[31:0];

endmodule // int16_multiply
`default_nettype wire

/* hw/fp_and_int16_multiply_unit.sv */
// Implementation choices: the Avalon-MM slave port and the register offsets.
`timescale 1ns/1ps
`default_nettype none
`include "mul_unit_cfg.svh"
module fp_and_int16_multiply_unit (
  input wire logic sys_clk, // Core clock
  input wire logic rstn, // Synchronous reset, active low
  input wire mul_unit_pkg::issue_type issue, // Operation in E1
  input wire logic [31:0] second_operand_high_word, // High src2 word in E2
  output logic unit_busy, // Unit held by a long operation
  output logic int_valid, // Halfword product write pulse
  output logic [31:0] int_result, // Halfword product
  output logic wb_low_valid, // Low or single word write pulse
  output logic [31:0] wb_low_data, // Low or single result word
  output mul_unit_pkg::fp_flags_type fp_flags, // Flags with low write
  output logic wb_high_valid, // High word write pulse
  output logic [31:0] wb_high_data, // High result word
  input wire logic [3:0] avs_address, // Avalon byte address
  input wire logic avs_read, // Avalon read
  input wire logic avs_write, // Avalon write
  input wire logic [31:0] avs_writedata, // Avalon write data
  output logic [31:0] avs_readdata, // Avalon read data
  output logic avs_waitrequest // Avalon wait
);

  mul_unit_pkg::issue_type s1_reg;
  mul_unit_pkg::op_class_type cls [2];
  mul_unit_pkg::wb_entry_type entry;
  mul_unit_pkg::wb_entry_type pipe_reg [`WB_PIPE_DEPTH];
  mul_unit_pkg::wb_entry_type feed [`WB_PIPE_DEPTH];
  mul_unit_pkg::wb_entry_type wb_low_reg;
  mul_unit_pkg::fp_flags_type flags_cmb;
  mul_unit_pkg::res_kind_type kind;
  logic busy_reg;
  logic accept;
  logic is_int;
  logic fp_go;
  logic long_go;
  logic short_go;
  logic is_single;
  logic sgn;
  logic [63:0] opnd [2];
  logic [31:0] int_prod;
  logic int_valid_reg;
  logic [31:0] int_result_reg;
  logic wb_high_valid_reg;
  logic [31:0] wb_high_data_reg;
  logic [23:0] man_a;
  logic [52:0] man_b;
  logic [76:0] prod;
  logic [76:0] norm;
  logic [12:0] e_dp;
  logic [53:0] dp_rnd;
  logic [12:0] dp_exp;
  logic [51:0] dp_frac;
  logic dp_inexact_flag;
  logic [24:0] sp_rnd;
  logic [12:0] sp_exp;
  logic [22:0] sp_frac;
  logic sp_inexact_flag;
  logic ovf;
  logic unf;
  logic [63:0] res;
  logic [3:0] status_reg;
  logic [3:0] status_next;
  logic capture_en_reg;
  logic wait_reg;
  logic [31:0] readdata_reg;
  logic bus_act;

  // Widen a single word into double layout, keeping class
  function automatic logic [63:0] widen_single(input logic [31:0] w);
    logic [12:0] tmp;
    logic [10:0] e;
    begin
      tmp = {5'h00, w[30:23]} + `SP_TO_DP_REBIAS;
      if (w[30:23] == 8'h00)
        e = 11'h000;
      else if (w[30:23] == `SP_EXP_MAX)
        e = `DP_EXP_MAX;
      else
        e = tmp[10:0];
      widen_single = {w[31], e, w[22:0], 29'h0000_0000};
    end
  endfunction

  // Issue acceptance; a false predicate is a no-operation
  assign accept = issue.valid && issue.pred && !busy_reg;
  assign is_int = (issue.op == mul_unit_pkg::mul16_signed_by_unsigned)
               || (issue.op == mul_unit_pkg::mul16_unsigned_both)
               || (issue.op == mul_unit_pkg::mul16_unsigned_by_signed);

  // Long operation holds the unit in E2 as well
  always_ff @(posedge sys_clk)
  begin
    if (!rstn)
      busy_reg <= 1'b0;
    else
      busy_reg <= accept && (issue.op == mul_unit_pkg::mul_single_by_double);
  end

  // Floating-point operands captured in E1
  always_ff @(posedge sys_clk)
  begin
    if (!rstn)
      s1_reg <= '0;
    else if (accept && !is_int)
      s1_reg <= issue;
    else
      s1_reg <= '0;
  end

  // Halfword multiplier, result written in E2
  int16_multiply u_int16 (
    .op(issue.op),
    .opfield(issue.opfield),
    .src1(issue.src1),
    .src2(issue.second_operand_low_word),
    .product(int_prod)
  );

  always_ff @(posedge sys_clk)
  begin
    if (!rstn)
    begin
      int_valid_reg <= 1'b0;
      int_result_reg <= 32'h0000_0000;
    end
    else
    begin
      int_valid_reg <= accept && is_int;
      if (accept && is_int)
        int_result_reg <= int_prod;
    end
  end

  // E2 operands: long operation takes the high src2 word now
  assign fp_go = s1_reg.valid && (s1_reg.op != mul_unit_pkg::op_idle);
  assign long_go = fp_go && (s1_reg.op == mul_unit_pkg::mul_single_by_double);
  assign short_go = fp_go && !long_go;
  assign is_single = (s1_reg.op == mul_unit_pkg::mul_single_single);
  assign opnd[0] = widen_single(s1_reg.src1);
  assign opnd[1] = long_go ? {second_operand_high_word, s1_reg.second_operand_low_word}
                           : widen_single(s1_reg.second_operand_low_word);

  // Classify both operands
  for (genvar i = 0; i < 2; i++)
  begin : g_class
    fp_operand_class u_class (
      .word(opnd[i]),
      .cls(cls[i])
    );
  end

  // Mantissa product and exponent in double bias
  assign man_a = {1'b1, cls[0].frac[51:29]};
  assign man_b = {1'b1, cls[1].frac};
  assign prod = man_a * man_b;
  assign norm = prod[76] ? prod : {prod[75:0], 1'b0};
  assign e_dp = {2'b00, cls[0].exp} + {2'b00, cls[1].exp} - `DP_BIAS + {12'h000, prod[76]};

  // Round to nearest even at double width
  assign dp_rnd = {1'b0, norm[76:24]} + {53'h0, norm[23] & ((|norm[22:0]) | norm[24])};
  assign dp_exp = e_dp + {12'h000, dp_rnd[53]};
  assign dp_frac = dp_rnd[53] ? 52'h0 : dp_rnd[51:0];
  assign dp_inexact_flag = norm[23] | (|norm[22:0]);

  // Round to nearest even at single width
  assign sp_rnd = {1'b0, norm[76:53]} + {24'h00_0000, norm[52] & ((|norm[51:0]) | norm[53])};
  assign sp_exp = e_dp - `SP_TO_DP_REBIAS + {12'h000, sp_rnd[24]};
  assign sp_frac = sp_rnd[24] ? 23'h00_0000 : sp_rnd[22:0];
  assign sp_inexact_flag = norm[52] | (|norm[51:0]);

  // Range of the rounded exponent
  assign ovf = is_single ? (!sp_exp[12] && sp_exp >= {5'h00, `SP_EXP_MAX})
                         : (!dp_exp[12] && dp_exp >= {2'b00, `DP_EXP_MAX});
  assign unf = is_single ? (sp_exp[12] || sp_exp == 13'h0000)
                         : (dp_exp[12] || dp_exp == 13'h0000);
  assign sgn = cls[0].sign ^ cls[1].sign;

  // Special values, by priority, and their flags
  always_comb
  begin
    kind = mul_unit_pkg::kind_finite;
    flags_cmb = '0;
    flags_cmb.denormal_input_flag = {cls[1].den, cls[0].den};
    if (cls[0].nan || cls[1].nan)
    begin
      kind = mul_unit_pkg::kind_nan;
      flags_cmb.invalid_op_flag = cls[0].snan || cls[1].snan;
    end
    else if ((cls[0].inf && cls[1].zero) || (cls[1].inf && cls[0].zero))
    begin
      kind = mul_unit_pkg::kind_nan;
      flags_cmb.invalid_op_flag = 1'b1;
    end
    else if (cls[0].inf || cls[1].inf)
      kind = mul_unit_pkg::kind_inf;
    else if (cls[0].zero || cls[1].zero)
    begin
      kind = mul_unit_pkg::kind_zero;
      flags_cmb.inexact_flag = (cls[0].den && !cls[1].zero)
                            || (cls[1].den && !cls[0].zero);
    end
    else if (ovf)
    begin
      kind = mul_unit_pkg::kind_inf;
      flags_cmb.inexact_flag = 1'b1;
    end
    else if (unf)
    begin
      kind = mul_unit_pkg::kind_zero;
      flags_cmb.inexact_flag = 1'b1;
    end
    else
      flags_cmb.inexact_flag = is_single ? sp_inexact_flag : dp_inexact_flag;
  end

  // Pack the result in the requested precision
  always_comb
  begin
    res = 64'h0000_0000_0000_0000;
    case (kind)
      mul_unit_pkg::kind_nan:
        res = is_single ? {32'h0000_0000, sgn, `NAN_SP_MAG} : {sgn, `NAN_DP_MAG};
      mul_unit_pkg::kind_inf:
        res = is_single ? {32'h0000_0000, sgn, `SP_EXP_MAX, 23'h00_0000}
                        : {sgn, `DP_EXP_MAX, 52'h0};
      mul_unit_pkg::kind_zero:
        res = is_single ? {32'h0000_0000, sgn, 31'h0000_0000} : {sgn, 63'h0};
      mul_unit_pkg::kind_finite:
        res = is_single ? {32'h0000_0000, sgn, sp_exp[7:0], sp_frac}
                        : {sgn, dp_exp[10:0], dp_frac};
      default:
        res = 64'h0000_0000_0000_0000;
    endcase
  end

  // Entry for the write-back delay line
  always_comb
  begin
    entry.valid = 1'b1;
    entry.has_high = !is_single;
    entry.flags = flags_cmb;
    entry.low = res[31:0];
    entry.high = res[63:32];
  end

  // Delay line: long op enters at the top, short ops at the bottom
  for (genvar i = 0; i < `WB_PIPE_DEPTH; i++)
  begin : g_pipe
    if (i == `WB_PIPE_DEPTH - 1)
    begin : g_top
      assign feed[i] = long_go ? entry : '0;
    end
    else
    begin : g_mid
      assign feed[i] = pipe_reg[i + 1];
    end
    always_ff @(posedge sys_clk)
    begin
      if (!rstn)
        pipe_reg[i] <= '0;
      else if (i == 0 && short_go)
        pipe_reg[i] <= entry;
      else
        pipe_reg[i] <= feed[i];
    end
  end

  // Low word out, high word one cycle later
  always_ff @(posedge sys_clk)
  begin
    if (!rstn)
    begin
      wb_low_reg <= '0;
      wb_high_valid_reg <= 1'b0;
      wb_high_data_reg <= 32'h0000_0000;
    end
    else
    begin
      wb_low_reg <= pipe_reg[0];
      wb_high_valid_reg <= wb_low_reg.valid && wb_low_reg.has_high;
      if (wb_low_reg.valid && wb_low_reg.has_high)
        wb_high_data_reg <= wb_low_reg.high;
    end
  end

  // Sticky flags; a new flag wins over a clear in the same cycle
  assign bus_act = (avs_read || avs_write) && !wait_reg;
  always_comb
  begin
    status_next = status_reg;
    if (bus_act && avs_write && avs_address == `REG_STATUS)
      status_next = status_reg & ~avs_writedata[3:0];
    if (wb_low_reg.valid && capture_en_reg)
      status_next = status_next | wb_low_reg.flags;
  end

  always_ff @(posedge sys_clk)
  begin
    if (!rstn)
      status_reg <= 4'h0;
    else
      status_reg <= status_next;
  end

  // Control register: flag capture enable
  always_ff @(posedge sys_clk)
  begin
    if (!rstn)
      capture_en_reg <= `CONTROL_RESET;
    else if (bus_act && avs_write && avs_address == `REG_CONTROL)
      capture_en_reg <= avs_writedata[0];
  end

  // Avalon slave: one wait cycle, data ready when wait drops
  always_ff @(posedge sys_clk)
  begin
    if (!rstn)
      wait_reg <= 1'b1;
    else
      wait_reg <= !((avs_read || avs_write) && wait_reg);
  end

  always_ff @(posedge sys_clk)
  begin
    if (!rstn)
      readdata_reg <= 32'h0000_0000;
    else if (avs_read && wait_reg)
    begin
      if (avs_address == `REG_STATUS)
        readdata_reg <= {23'h00_0000, busy_reg, 4'h0, status_reg};
      else if (avs_address == `REG_CONTROL)
        readdata_reg <= {31'h0000_0000, capture_en_reg};
      else
        readdata_reg <= 32'h0000_0000;
    end
  end

  // Outputs straight from flops
  assign unit_busy = busy_reg;
  assign int_valid = int_valid_reg;
  assign int_result = int_result_reg;
  assign wb_low_valid = wb_low_reg.valid;
  assign wb_low_data = wb_low_reg.low;
  assign fp_flags = wb_low_reg.flags;
  assign wb_high_valid = wb_high_valid_reg;
  assign wb_high_data = wb_high_data_reg;
  assign avs_readdata = readdata_reg;
  assign avs_waitrequest = wait_reg;

  // Checks
  a_long_low_timing: assert property (@(posedge sys_clk) disable iff (!rstn)
    accept && issue.op == mul_unit_pkg::mul_single_by_double
    |-> !wb_low_valid ##5 wb_low_valid ##1 wb_high_valid)
    else $error("long multiply low/high write not in E6/E7");

  a_short_dp_timing: assert property (@(posedge sys_clk) disable iff (!rstn)
    accept && issue.op == mul_unit_pkg::mul_two_single_to_double
    |-> ##3 wb_low_valid ##1 wb_high_valid)
    else $error("two-single multiply not written in E4/E5");

  a_single_timing: assert property (@(posedge sys_clk) disable iff (!rstn)
    accept && issue.op == mul_unit_pkg::mul_single_single
    |-> ##3 wb_low_valid && !fp_flags_unused_high(wb_low_reg) ##1 !wb_high_valid)
    else $error("single multiply not written alone in E4");

  a_high_after_low: assert property (@(posedge sys_clk) disable iff (!rstn)
    wb_high_valid |-> $past(wb_low_valid) && $past(wb_low_reg.high) == wb_high_data)
    else $error("high word not one cycle after low word");

  a_int_timing: assert property (@(posedge sys_clk) disable iff (!rstn)
    accept && is_int |=> int_valid && int_result == $past(int_prod))
    else $error("halfword product not written in E2");

  a_pred_quiet: assert property (@(posedge sys_clk) disable iff (!rstn)
    issue.valid && !issue.pred && !$past(accept) && !busy_reg
    |=> !int_valid && !s1_reg.valid)
    else $error("false predicate started an operation");

  a_nan_sign: assert property (@(posedge sys_clk) disable iff (!rstn)
    fp_go && kind == mul_unit_pkg::kind_nan
    |-> (is_single ? res[31] : res[63]) == (cls[0].sign ^ cls[1].sign)
        ##1 (pipe_reg[0].valid || pipe_reg[`WB_PIPE_DEPTH - 1].valid))
    else $error("NaN result sign is not XOR of inputs");

  a_snan_invalid: assert property (@(posedge sys_clk) disable iff (!rstn)
    fp_go && (cls[0].snan || cls[1].snan) |-> flags_cmb.invalid_op_flag)
    else $error("signalling NaN without invalid flag");

  a_inf_zero_nan: assert property (@(posedge sys_clk) disable iff (!rstn)
    fp_go && ((cls[0].inf && cls[1].zero) || (cls[1].inf && cls[0].zero))
    |-> kind == mul_unit_pkg::kind_nan && flags_cmb.invalid_op_flag)
    else $error("infinity times zero not NaN with invalid");

  a_den_flag: assert property (@(posedge sys_clk) disable iff (!rstn)
    fp_go && cls[0].den && !cls[1].nan && !cls[1].inf
    |-> kind == mul_unit_pkg::kind_zero && flags_cmb.denormal_input_flag[0])
    else $error("denormal first source not zero with flag");

  a_bus_answer: assert property (@(posedge sys_clk) disable iff (!rstn)
    (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
    else $error("bus request not answered after one wait cycle");

  // Single results carry no high word
  function automatic logic fp_flags_unused_high(input mul_unit_pkg::wb_entry_type e);
    fp_flags_unused_high = e.has_high;
  endfunction

endmodule // fp_and_int16_multiply_unit
`default_nettype wire

/* sim/mul_issue_model.sv */
`timescale 1ns/1ps
`default_nettype none
module mul_issue_model (
  input wire logic sys_clk, // Core clock
  input wire logic unit_busy, // Unit held by a long operation
  output var mul_unit_pkg::issue_type issue, // Operation in E1
  output logic [31:0] hi_word // High src2 word, E2 only
);
  logic hi_live;
  logic [31:0] hi_val;

  // High word only meaningful in E2; otherwise it flips every cycle
  always @(posedge sys_clk)
  begin
    if (hi_live)
      hi_word <= hi_val;
    else
      hi_word <= ~hi_word;
  end

  // Quiet issue port at time zero
  initial
  begin
    issue = '0;
    hi_word = 32'h0000_0000;
    hi_live = 1'b0;
    hi_val = 32'h0000_0000;
  end

  // One operation in E1, its high word in E2; waits while unit_busy is high
  task automatic send(input mul_unit_pkg::issue_type t, input logic [31:0] h);
    @(posedge sys_clk);
    while (unit_busy === 1'b1)
      @(posedge sys_clk);
    issue <= t;
    hi_val <= h;
    hi_live <= 1'b1;
    @(posedge sys_clk);
    issue <= '0;
    hi_live <= 1'b0;
  endtask
endmodule // mul_issue_model
`default_nettype wire

/* sim/fp_and_int16_multiply_unit_tb.sv */
`timescale 1ns/1ps
`default_nettype none
module fp_and_int16_multiply_unit_tb;
  localparam mul_unit_pkg::mul_op_type ss = mul_unit_pkg::mul_single_single;
  localparam mul_unit_pkg::mul_op_type s2d = mul_unit_pkg::mul_two_single_to_double;
  localparam mul_unit_pkg::mul_op_type sd = mul_unit_pkg::mul_single_by_double;
  logic sys_clk = 1'b0;
  logic rstn = 1'b0;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [3:0] avs_address = 4'h0;
  logic [31:0] avs_writedata = 32'h0000_0000;
  mul_unit_pkg::issue_type issue;
  mul_unit_pkg::fp_flags_type fp_flags;
  logic [31:0] hi_word, int_result, wb_low_data, wb_high_data, avs_readdata;
  logic unit_busy, int_valid, wb_low_valid, wb_high_valid, avs_waitrequest;
  int err_total = 0;
  int n_compared = 0;

  // Core clock, 50 ns
  always #25 sys_clk = ~sys_clk;

  mul_issue_model i_mul_issue_model (.sys_clk(sys_clk), .unit_busy(unit_busy),
    .issue(issue), .hi_word(hi_word));

  fp_and_int16_multiply_unit i_fp_and_int16_multiply_unit (.sys_clk(sys_clk), .rstn(rstn),
    .issue(issue), .second_operand_high_word(hi_word), .unit_busy(unit_busy),
    .int_valid(int_valid), .int_result(int_result), .wb_low_valid(wb_low_valid),
    .wb_low_data(wb_low_data), .fp_flags(fp_flags), .wb_high_valid(wb_high_valid),
    .wb_high_data(wb_high_data), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest));

  // Counts and verdict
  task automatic end_sim();
    $display("compared %0d mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  // Compare one value
  task automatic chk(input string w, input logic [63:0] e, input logic [63:0] g);
    n_compared++;
    if (g !== e)
    begin
      err_total++;
      $display("[FAIL] %s expected %h seen %h", w, e, g);
    end
  endtask

  // One Avalon transfer, held until waitrequest is sampled low
  task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d,
                     output logic [31:0] q);
    int n;
    n = 0;
    @(posedge sys_clk);
    avs_address <= a;
    avs_writedata <= d;
    avs_read <= !w;
    avs_write <= w;
    @(posedge sys_clk);
    while (avs_waitrequest !== 1'b0 && n < 20)
    begin
      n++;
      @(posedge sys_clk);
    end
    q = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    if (n == 20)
      chk("bus wait", 64'h0, 64'h1);
  endtask

  task automatic rd(input logic [3:0] a, input logic [31:0] e, input string w);
    logic [31:0] q;
    bus(1'b0, a, 32'h0000_0000, q);
    chk(w, 64'(e), 64'(q));
  endtask

  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask

  // Issue one operation and check its write-back at the expected cycles
  task automatic run(input mul_unit_pkg::mul_op_type op, input logic [4:0] f,
                     input logic [31:0] a, input logic [31:0] b, input logic [31:0] h,
                     input logic [31:0] eh, input logic [31:0] el, input logic [3:0] ef);
    int k;
    k = (op == sd) ? 4 : ((op == ss || op == s2d) ? 2 : 0);
    i_mul_issue_model.send('{1'b1, 1'b1, op, f, a, b}, h);
    #1;
    if (k == 0)
      chk("int", 64'({1'b1, el}), 64'({int_valid, int_result}));
    if (k == 4)
      chk("busy", 64'(1'b1), 64'(unit_busy));
    if (k > 0)
    begin
      repeat (k) @(posedge sys_clk);
      #1;
      chk("low", {26'h0, 1'b1, ef, el, 1'b0},
          {26'h0, wb_low_valid, fp_flags, wb_low_data, wb_high_valid});
      @(posedge sys_clk);
      #1;
      chk("high", 64'(op != ss), 64'(wb_high_valid));
      if (op != ss)
        chk("hdata", 64'(eh), 64'(wb_high_data));
    end
  endtask

  // Watchdog, about thirty times the expected run length
  initial
  begin
    #(50 * 4000);
    err_total++;
    end_sim();
  end

  // Test sequence
  initial
  begin
    repeat (2) @(posedge sys_clk);
    rstn <= 1'b1;
    #1;
    chk("reset", 64'h8, 64'({avs_waitrequest, int_valid, wb_low_valid, wb_high_valid}));
    rd(4'h4, 32'h0000_0001, "control");
    rd(4'hc, 32'h0000_0000, "unmapped");
    $display("test registers done");
    run(mul_unit_pkg::mul16_signed_by_unsigned, 5'h1b, 32'h0000_ffff, 32'hffff_ffff,
        32'h0, 32'h0, 32'hffff_0001, 4'h0);
    run(mul_unit_pkg::mul16_signed_by_unsigned, 5'h1e, 32'h0000_00fd, 32'h0000_0005,
        32'h0, 32'h0, 32'hffff_fff1, 4'h0);
    run(mul_unit_pkg::mul16_unsigned_both, 5'h00, 32'h0000_0123, 32'h0f12_fa81,
        32'h0, 32'h0, 32'h011c_c0a3, 4'h0);
    run(mul_unit_pkg::mul16_unsigned_by_signed, 5'h00, 32'h1234_ffff, 32'h0000_ffff,
        32'h0, 32'h0, 32'hffff_0001, 4'h0);
    $display("test halfword done");
    run(ss, 5'h0, 32'hc020_0000, 32'h4109_999a, 0, 0, 32'hc1ac_0000, 4'h4);
    run(ss, 5'h0, 32'hff80_0000, 32'h4000_0000, 0, 0, 32'hff80_0000, 4'h0);
    run(ss, 5'h0, 32'h7f80_0000, 32'hff80_0000, 0, 0, 32'hff80_0000, 4'h0);
    run(ss, 5'h0, 32'h7f80_0000, 32'h0000_0000, 0, 0, 32'h7fff_ffff, 4'h8);
    run(ss, 5'h0, 32'h8000_0000, 32'h4000_0000, 0, 0, 32'h8000_0000, 4'h0);
    run(ss, 5'h0, 32'h0000_0000, 32'h7fc0_0000, 0, 0, 32'h7fff_ffff, 4'h0);
    run(ss, 5'h0, 32'h7f80_0000, 32'h8000_0001, 0, 0, 32'hffff_ffff, 4'ha);
    run(s2d, 5'h0, 32'h4000_0000, 32'h4040_0000, 0, 32'h4018_0000, 0, 4'h0);
    run(s2d, 5'h0, 32'h7f80_0001, 32'hbf80_0000, 0, 32'hffff_ffff, 32'hffff_ffff,
        4'h8);
    run(sd, 5'h0, 32'h4000_0000, 32'h0000_0000, 32'h3ff8_0000, 32'h4008_0000, 0,
        4'h0);
    run(sd, 5'h0, 32'hbf80_0000, 32'h0000_0001, 32'h7ff0_0000, 32'hffff_ffff,
        32'hffff_ffff, 4'h8);
    $display("test float done");
    wr(4'h0, 32'h0000_000f);
    run(ss, 5'h0, 32'h0000_0001, 32'h4000_0000, 0, 0, 32'h0000_0000, 4'h5);
    rd(4'h0, 32'h0000_0005, "status sticky");
    wr(4'h4, 32'h0000_0000);
    run(ss, 5'h0, 32'h7f80_0000, 32'h0000_0000, 0, 0, 32'h7fff_ffff, 4'h8);
    rd(4'h0, 32'h0000_0005, "status capture off");
    wr(4'h0, 32'h0000_0005);
    wr(4'hc, 32'hffff_ffff);
    rd(4'h4, 32'h0000_0000, "control kept");
    wr(4'h4, 32'h0000_0001);
    i_mul_issue_model.send('{1'b1, 1'b0, sd, 5'h00, 32'h7f80_0001, 32'h0}, 32'h0);
    repeat (7)
    begin
      #1;
      chk("quiet", 64'h0, 64'({unit_busy, int_valid, wb_low_valid, wb_high_valid}));
      @(posedge sys_clk);
    end
    rd(4'h0, 32'h0000_0000, "status quiet");
    $display("test status done");
    end_sim();
  end
endmodule // fp_and_int16_multiply_unit_tb
`default_nettype wire
